/* dual_half_general_timer_consts.svh */
`ifndef DUAL_HALF_GENERAL_TIMER_CONSTS_SVH
`define DUAL_HALF_GENERAL_TIMER_CONSTS_SVH

// ****************************************************************
// Reset values and RTC start value
// ****************************************************************
`define DHGT_CNT_RST        16'hFFFF
`define DHGT_LOAD_RST       16'hFFFF
`define DHGT_PRE_RST        8'h00
`define DHGT_MATCH_RST      16'h0000
`define DHGT_CTL_RST        16'h0000
`define DHGT_RTC_FIRST      32'h00000001

// ****************************************************************
// Control word layout, one byte per half
// ****************************************************************
`define DHGT_CTL_HALF_W     8
`define DHGT_CTL_EN         0
`define DHGT_CTL_STALL      1
`define DHGT_CTL_TRIG       2
`define DHGT_CTL_INV        3
`define DHGT_CTL_EVT_LO     4
`define DHGT_CTL_EVT_HI     5

// ****************************************************************
// Mode field layout
// ****************************************************************
`define DHGT_MODE_MR_LO     0
`define DHGT_MODE_MR_HI     1
`define DHGT_MODE_CAPT_TIME 2
`define DHGT_MODE_PWM       3

// ****************************************************************
// Timing: slow clock on the even pin and its divided rate
// ****************************************************************
`define DHGT_RTC_IN_HZ      32768
`define DHGT_RTC_OUT_HZ     1

`endif

/* dual_half_general_timer_pkg.sv */
// ****************************************************************
// Types shared by the timer block
// ****************************************************************
package dual_half_general_timer_pkg;

    // Width configuration codes
    typedef enum logic [2:0] {
        CFG_TIMER32 = 3'h0,
        CFG_RTC32   = 3'h1,
        CFG_SPLIT16 = 3'h4
    } width_cfg_e;

    // Per-half count mode field
    typedef enum logic [1:0] {
        MR_NONE     = 2'h0,
        MR_ONESHOT  = 2'h1,
        MR_PERIODIC = 2'h2,
        MR_CAPTURE  = 2'h3
    } half_mode_e;

    // Edge selection codes
    typedef enum logic [1:0] {
        EVT_RISE = 2'h0,
        EVT_FALL = 2'h1,
        EVT_RSVD = 2'h2,
        EVT_BOTH = 2'h3
    } edge_sel_e;

endpackage

/* dual_half_general_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dual_half_general_timer_consts.svh"

// How it works
// [RULE1] Triggers ORed to one line
// [RULE2] Trigger on one timer only
// [RULE3] Two 16-bit halves or one 32-bit
// [RULE4] Joined one timer; split halves free
// [RULE5] Joined one-shot, periodic or RTC
// [RULE6] 8-bit prescale, timer modes only
// [RULE7] Halt stalls count if enabled; the RTC config ignores the stall bit
// [RULE8] Capture: edge count or edge time
// [RULE9] PWM per half, invertible
// [RULE10] Block 3 has no pins
// [RULE11] Pins are GPIO until selected
// [RULE12] Software selects pin function first
// [RULE13] Count, match, prescale, load per half
// [RULE14] Config plus two mode words
// [RULE15] Reset: idle, controls cleared
// [RULE16] Counts, loads reset to FFFF
// [RULE17] Prescales reset to zero
// [RULE18] Config 0 timer, 1 RTC
// [RULE19] Config 4 splits
// [RULE20] Wide access spans both halves
// [RULE21] Trigger pulses one cycle
module dual_half_general_timer #(
    parameter int BLOCK_INDEX = 0,
    parameter int RTC_DIV     = `DHGT_RTC_IN_HZ / `DHGT_RTC_OUT_HZ
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic [2:0]  CFG_I,
    input  wire logic [3:0]  MODE_A_I,
    input  wire logic [3:0]  MODE_B_I,
    input  wire logic        CTL_WR_I,
    input  wire logic [15:0] CTL_DATA_I,
    input  wire logic [1:0]  LOAD_WR_I,
    input  wire logic [31:0] LOAD_DATA_I,
    input  wire logic [1:0]  PRESCALE_WR_I,
    input  wire logic [15:0] PRESCALE_DATA_I,
    input  wire logic [1:0]  MATCH_WR_I,
    input  wire logic [31:0] MATCH_DATA_I,
    input  wire logic        HALT_I,
    input  wire logic [1:0]  ALT_SEL_I,
    input  wire logic [1:0]  TIMER_PIN_I,
    output logic      [1:0]  TIMER_PIN_O,
    output logic      [1:0]  TIMER_PIN_OE_O,
    input  wire logic        ADC_TRIG_CHAIN_I,
    output logic             ADC_TRIG_O,
    output logic      [31:0] COUNT_O,
    output logic      [31:0] CAPTURE_O,
    output logic      [15:0] CTL_O,
    output logic      [1:0]  TIMEOUT_O
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial begin
        if (BLOCK_INDEX < 0 || BLOCK_INDEX > 3) begin
            $error("BLOCK_INDEX must be 0 to 3");
        end
        if (RTC_DIV < 2 || RTC_DIV > 65536) begin
            $error("RTC_DIV must be 2 to 65536");
        end
    end

    // Block 3 has no pins
    localparam logic HAS_PINS = (BLOCK_INDEX < 3); // [RULE10]
    localparam logic [15:0] RTC_LAST = 16'(RTC_DIV - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [1:0][15:0] cnt_q, cnt_d;          // Half counters
    logic [1:0][15:0] load_q, load_d;        // Interval load values
    logic [1:0][7:0]  pre_load_q, pre_load_d; // Prescale reload values
    logic [1:0][7:0]  pre_cnt_q, pre_cnt_d;  // Running prescale counts
    logic [1:0][15:0] match_q, match_d;      // Match values
    logic [1:0][15:0] capt_q, capt_d;        // Edge-time snapshots
    logic [15:0]      ctl_q, ctl_d;          // Control word
    logic [1:0]       pwm_q, pwm_d;          // Raw waveform levels
    logic [1:0]       pin_prev_q;            // Last pin sample
    logic [1:0]       tmo_q, tmo_d;          // Timeout pulses
    logic             trig_q, trig_d;        // Own converter trigger
    logic [15:0]      div_q, div_d;          // Slow-clock divider

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // One process: joined modes write both halves
    always_comb begin
        logic [3:0]  mode;
        logic [7:0]  hc;
        logic        run;
        logic        edge_hit;
        logic [31:0] c32;
        logic [31:0] m32;
        mode     = 4'h0;
        hc       = 8'h00;
        run      = 1'b0;
        edge_hit = 1'b0;
        c32      = {cnt_q[1], cnt_q[0]};
        m32      = {match_q[1], match_q[0]};
        cnt_d      = cnt_q;
        load_d     = load_q;
        pre_load_d = pre_load_q;
        pre_cnt_d  = pre_cnt_q;
        match_d    = match_q;
        capt_d     = capt_q;
        ctl_d      = ctl_q;
        pwm_d      = pwm_q;
        div_d      = div_q;
        tmo_d      = 2'b00;
        // Software write beats a hardware enable clear
        if (CTL_WR_I) begin
            ctl_d = CTL_DATA_I; // [RULE14]
        end
        unique case (CFG_I)
            dual_half_general_timer_pkg::CFG_SPLIT16: begin // [RULE3] [RULE19]
                // Each half follows its own mode word
                for (int n = 0; n < 2; n++) begin // [RULE4]
                    mode = (n == 0) ? MODE_A_I : MODE_B_I; // [RULE14]
                    hc   = ctl_q[n*`DHGT_CTL_HALF_W +: `DHGT_CTL_HALF_W];
                    run  = hc[`DHGT_CTL_EN] && !(hc[`DHGT_CTL_STALL] && HALT_I); // [RULE7]
                    // Pins ignored until selected
                    edge_hit = 1'b0;
                    if (HAS_PINS && ALT_SEL_I[n]) begin // [RULE11]
                        unique case (hc[`DHGT_CTL_EVT_HI:`DHGT_CTL_EVT_LO])
                            dual_half_general_timer_pkg::EVT_RISE:
                                edge_hit = TIMER_PIN_I[n] && !pin_prev_q[n];
                            dual_half_general_timer_pkg::EVT_FALL:
                                edge_hit = !TIMER_PIN_I[n] && pin_prev_q[n];
                            default:
                                edge_hit = TIMER_PIN_I[n] != pin_prev_q[n];
                        endcase
                    end
                    if (mode[`DHGT_MODE_PWM]) begin
                        // Waveform: high from reload, low from match
                        if (run) begin // [RULE9]
                            if (cnt_q[n] == 16'h0000) begin
                                cnt_d[n] = load_q[n];
                                pwm_d[n] = 1'b1;
                            end else begin
                                cnt_d[n] = cnt_q[n] - 16'h0001;
                                if (cnt_q[n] == match_q[n]) begin
                                    pwm_d[n] = 1'b0;
                                end
                            end
                        end
                    end else if (mode[`DHGT_MODE_MR_HI:`DHGT_MODE_MR_LO]
                                 == dual_half_general_timer_pkg::MR_CAPTURE) begin
                        if (mode[`DHGT_MODE_CAPT_TIME]) begin
                            // Edge time: free-running count, snapshot on edge
                            if (run) begin // [RULE8]
                                cnt_d[n] = (cnt_q[n] == 16'h0000) ? load_q[n]
                                                                  : cnt_q[n] - 16'h0001;
                                if (edge_hit) begin
                                    capt_d[n] = cnt_q[n];
                                    tmo_d[n]  = 1'b1;
                                end
                            end
                        end else if (run && edge_hit) begin
                            // Edge count: an edge that finds the count at the match reloads and stops
                            if (cnt_q[n] == match_q[n]) begin // [RULE8]
                                cnt_d[n] = load_q[n];
                                ctl_d[n*`DHGT_CTL_HALF_W + `DHGT_CTL_EN] &= CTL_WR_I;
                                tmo_d[n] = 1'b1;
                            end else begin
                                cnt_d[n] = cnt_q[n] - 16'h0001;
                            end
                        end
                    end else if (run && mode[`DHGT_MODE_MR_HI:`DHGT_MODE_MR_LO]
                                 != dual_half_general_timer_pkg::MR_NONE) begin
                        // One-shot or periodic, prescaled
                        if (pre_cnt_q[n] != 8'h00) begin // [RULE6]
                            pre_cnt_d[n] = pre_cnt_q[n] - 8'h01;
                        end else if (cnt_q[n] == 16'h0000) begin
                            cnt_d[n]     = load_q[n];
                            pre_cnt_d[n] = pre_load_q[n];
                            tmo_d[n]     = 1'b1;
                            if (mode[`DHGT_MODE_MR_HI:`DHGT_MODE_MR_LO]
                                == dual_half_general_timer_pkg::MR_ONESHOT) begin
                                ctl_d[n*`DHGT_CTL_HALF_W + `DHGT_CTL_EN] &= CTL_WR_I;
                            end
                        end else begin
                            cnt_d[n]     = cnt_q[n] - 16'h0001;
                            pre_cnt_d[n] = pre_load_q[n];
                        end
                    end
                    // Writes after counting, so they win
                    if (PRESCALE_WR_I[n]) begin
                        pre_load_d[n] = PRESCALE_DATA_I[n*8 +: 8];
                    end
                    if (MATCH_WR_I[n]) begin
                        match_d[n] = MATCH_DATA_I[n*16 +: 16];
                    end
                    if (LOAD_WR_I[n]) begin
                        load_d[n] = LOAD_DATA_I[n*16 +: 16];
                        cnt_d[n]  = LOAD_DATA_I[n*16 +: 16];
                    end
                end
            end
            dual_half_general_timer_pkg::CFG_RTC32: begin
                // Up-count; stall never applies
                if (ctl_q[`DHGT_CTL_EN] && HAS_PINS && ALT_SEL_I[0] &&
                    TIMER_PIN_I[0] && !pin_prev_q[0]) begin // [RULE5]
                    if (div_q == RTC_LAST) begin
                        div_d = 16'h0000;
                        if (c32 == m32) begin
                            c32      = 32'h00000000;
                            tmo_d[0] = 1'b1;
                        end else begin
                            c32 = c32 + 32'h00000001;
                        end
                    end else begin
                        div_d = div_q + 16'h0001;
                    end
                end
                // First enable starts the clock from one
                if (ctl_d[`DHGT_CTL_EN] && !ctl_q[`DHGT_CTL_EN]) begin // [RULE18]
                    c32   = `DHGT_RTC_FIRST;
                    div_d = 16'h0000;
                end
                if (MATCH_WR_I[0]) begin
                    match_d = MATCH_DATA_I; // [RULE20]
                end
                if (LOAD_WR_I[0]) begin
                    load_d = LOAD_DATA_I; // [RULE20]
                end
                {cnt_d[1], cnt_d[0]} = c32;
            end
            default: begin
                // Joined down-counter; mode A picks kind
                run = ctl_q[`DHGT_CTL_EN] && !(ctl_q[`DHGT_CTL_STALL] && HALT_I); // [RULE7]
                if (run) begin // [RULE5]
                    if (c32 == 32'h00000000) begin
                        c32      = {load_q[1], load_q[0]};
                        tmo_d[0] = 1'b1;
                        if (MODE_A_I[`DHGT_MODE_MR_HI:`DHGT_MODE_MR_LO]
                            == dual_half_general_timer_pkg::MR_ONESHOT) begin
                            ctl_d[`DHGT_CTL_EN] &= CTL_WR_I;
                        end
                    end else begin
                        c32 = c32 - 32'h00000001;
                    end
                end
                if (MATCH_WR_I[0]) begin
                    match_d = MATCH_DATA_I;
                end
                // Wide write, upper word to half B
                if (LOAD_WR_I[0]) begin // [RULE20]
                    load_d = LOAD_DATA_I;
                    c32    = LOAD_DATA_I;
                end
                {cnt_d[1], cnt_d[0]} = c32; // [RULE18]
            end
        endcase
        // Enabled halves only
        trig_d = |(tmo_d & {ctl_q[`DHGT_CTL_HALF_W + `DHGT_CTL_TRIG],
                            ctl_q[`DHGT_CTL_TRIG]}); // [RULE21]
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Reset: idle, all-ones counters
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_q      <= {2{`DHGT_CNT_RST}};  // [RULE16]
            load_q     <= {2{`DHGT_LOAD_RST}}; // [RULE16]
            pre_load_q <= {2{`DHGT_PRE_RST}};  // [RULE17]
            pre_cnt_q  <= {2{`DHGT_PRE_RST}};  // [RULE17]
            match_q    <= {2{`DHGT_MATCH_RST}};
            capt_q     <= {2{`DHGT_MATCH_RST}};
            ctl_q      <= `DHGT_CTL_RST;       // [RULE15]
            pwm_q      <= 2'b00;
            pin_prev_q <= 2'b00;
            tmo_q      <= 2'b00;
            trig_q     <= 1'b0;
            div_q      <= 16'h0000;
        end else begin
            cnt_q      <= cnt_d;  // [RULE13]
            load_q     <= load_d;
            pre_load_q <= pre_load_d;
            pre_cnt_q  <= pre_cnt_d;
            match_q    <= match_d;
            capt_q     <= capt_d;
            ctl_q      <= ctl_d;
            pwm_q      <= pwm_d;
            pin_prev_q <= TIMER_PIN_I;
            tmo_q      <= tmo_d;
            trig_q     <= trig_d;
            div_q      <= div_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Half B above half A
    assign COUNT_O   = {cnt_q[1], cnt_q[0]}; // [RULE20]
    assign CAPTURE_O = {capt_q[1], capt_q[0]};
    assign CTL_O     = ctl_q;
    assign TIMEOUT_O = tmo_q;
    // Merged sources cannot be told apart
    assign ADC_TRIG_O = trig_q | ADC_TRIG_CHAIN_I; // [RULE1]

    // Drive only in split PWM with pin selected
    assign TIMER_PIN_O[0]    = pwm_q[0] ^ ctl_q[`DHGT_CTL_INV]; // [RULE9]
    assign TIMER_PIN_O[1]    = pwm_q[1] ^ ctl_q[`DHGT_CTL_HALF_W + `DHGT_CTL_INV];
    assign TIMER_PIN_OE_O[0] = HAS_PINS && ALT_SEL_I[0] && MODE_A_I[`DHGT_MODE_PWM] &&
                               CFG_I == dual_half_general_timer_pkg::CFG_SPLIT16; // [RULE11]
    assign TIMER_PIN_OE_O[1] = HAS_PINS && ALT_SEL_I[1] && MODE_B_I[`DHGT_MODE_PWM] &&
                               CFG_I == dual_half_general_timer_pkg::CFG_SPLIT16; // [RULE10]

endmodule
`default_nettype wire

/* dual_half_general_timer_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port checker for the timer block
// ****************************************************************
module dual_half_general_timer_chk (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic [2:0]  CFG_I,
    input  wire logic [3:0]  MODE_A_I,
    input  wire logic        CTL_WR_I,
    input  wire logic [15:0] CTL_DATA_I,
    input  wire logic [1:0]  LOAD_WR_I,
    input  wire logic [31:0] LOAD_DATA_I,
    input  wire logic        HALT_I,
    input  wire logic [1:0]  ALT_SEL_I,
    input  wire logic [1:0]  TIMER_PIN_OE_O,
    input  wire logic        ADC_TRIG_CHAIN_I,
    input  wire logic        ADC_TRIG_O,
    input  wire logic [31:0] COUNT_O,
    input  wire logic [15:0] CTL_O,
    input  wire logic [1:0]  TIMEOUT_O
);
    // One clock domain
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    // First RTC enable
    sequence s_rtc_go;
        CFG_I == 3'h1 && CTL_WR_I && CTL_DATA_I[0] && !CTL_O[0] && LOAD_WR_I == 2'h0;
    endsequence
    // Undisturbed joined one-shot end
    sequence s_shot_end;
        $rose(TIMEOUT_O[0]) && CFG_I == 3'h0 && MODE_A_I[1:0] == 2'h1 && !$past(CTL_WR_I);
    endsequence

    a_reset_state: assert property ($rose(RST_N_I) |->
        COUNT_O == 32'hFFFFFFFF && CTL_O == 16'h0000 && TIMEOUT_O == 2'h0)
        else $error("bad reset state");
    a_pin_gpio: assert property ((TIMER_PIN_OE_O & ~ALT_SEL_I) == 2'h0)
        else $error("pin driven unselected");
    a_rtc_input: assert property (CFG_I == 3'h1 |-> !TIMER_PIN_OE_O[0])
        else $error("RTC pin driven");
    a_trig_chain: assert property (ADC_TRIG_CHAIN_I |-> ADC_TRIG_O)
        else $error("chained trigger lost");
    a_trig_quiet: assert property (!ADC_TRIG_CHAIN_I && TIMEOUT_O == 2'h0 |-> !ADC_TRIG_O)
        else $error("trigger without timeout");
    a_trig_own: assert property (TIMEOUT_O[0] && CTL_O[2] && $stable(CTL_O[2]) |-> ADC_TRIG_O)
        else $error("no trigger");
    a_load_split: assert property (CFG_I == 3'h4 && LOAD_WR_I[0] |=>
        COUNT_O[15:0] == $past(LOAD_DATA_I[15:0]))
        else $error("half load not taken");
    a_load_joined: assert property (CFG_I == 3'h0 && LOAD_WR_I[0] |=>
        COUNT_O == $past(LOAD_DATA_I))
        else $error("joined load not taken");
    a_stall_hold: assert property (CFG_I == 3'h4 && MODE_A_I == 4'h2 && HALT_I && CTL_O[1]
        && !LOAD_WR_I[0] |=> COUNT_O[15:0] == $past(COUNT_O[15:0]))
        else $error("stall failed");
    a_rtc_start: assert property (s_rtc_go |=> COUNT_O == 32'h00000001)
        else $error("RTC not at one");
    a_shot_stop: assert property (s_shot_end |-> ##[0:1] !CTL_O[0])
        else $error("one-shot kept its enable");
endmodule

bind dual_half_general_timer dual_half_general_timer_chk i_chk (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CFG_I(CFG_I), .MODE_A_I(MODE_A_I),
    .CTL_WR_I(CTL_WR_I), .CTL_DATA_I(CTL_DATA_I), .LOAD_WR_I(LOAD_WR_I),
    .LOAD_DATA_I(LOAD_DATA_I), .HALT_I(HALT_I), .ALT_SEL_I(ALT_SEL_I),
    .TIMER_PIN_OE_O(TIMER_PIN_OE_O), .ADC_TRIG_CHAIN_I(ADC_TRIG_CHAIN_I),
    .ADC_TRIG_O(ADC_TRIG_O), .COUNT_O(COUNT_O), .CTL_O(CTL_O), .TIMEOUT_O(TIMEOUT_O)
);
`default_nettype wire

/* pin_partner.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Far side of the timer pins
// ****************************************************************
module pin_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] en_i,    // Toggling allowed per pin
    input  wire logic [1:0] drv_i,   // Level the timer drives
    input  wire logic [1:0] oe_i,    // Timer owns the wire
    output logic      [1:0] pin_o    // Resolved wire level
);
    logic [1:0] lvl_q;  // Level this side drives
    logic [1:0] div_q;  // Hold counter
    // Levels held three cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= 2'h0;
            div_q <= 2'h0;
        end else begin
            div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            if (div_q == 2'h2) begin
                lvl_q <= ~lvl_q & en_i;  // Stands low when idle
            end
        end
    end
    // The timer wins the wire whenever it drives
    assign pin_o = (oe_i & drv_i) | (~oe_i & lvl_q);
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Self-checking bench
// ****************************************************************
module tb_top;
    logic        clk, rst_n, ctl_wr, halt, trig_chain, adc_trig;
    logic [2:0]  cfg;
    logic [3:0]  mode_a, mode_b;
    logic [15:0] ctl_data, pre_data, ctl_o, snap;
    logic [1:0]  load_wr, pre_wr, match_wr, alt_sel, pin_i, pin_o, pin_oe, tmo, part_en;
    logic [31:0] load_data, match_data, count, capture;
    int          n_mismatch, tests_run, i, k, lv, pv, mv, hi;

    // Short RTC divider
    dual_half_general_timer #(.BLOCK_INDEX(0), .RTC_DIV(4)) i_dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .CFG_I(cfg), .MODE_A_I(mode_a), .MODE_B_I(mode_b),
        .CTL_WR_I(ctl_wr), .CTL_DATA_I(ctl_data), .LOAD_WR_I(load_wr), .LOAD_DATA_I(load_data),
        .PRESCALE_WR_I(pre_wr), .PRESCALE_DATA_I(pre_data), .MATCH_WR_I(match_wr),
        .MATCH_DATA_I(match_data), .HALT_I(halt), .ALT_SEL_I(alt_sel), .TIMER_PIN_I(pin_i),
        .TIMER_PIN_O(pin_o), .TIMER_PIN_OE_O(pin_oe), .ADC_TRIG_CHAIN_I(trig_chain),
        .ADC_TRIG_O(adc_trig), .COUNT_O(count), .CAPTURE_O(capture), .CTL_O(ctl_o),
        .TIMEOUT_O(tmo));
    pin_partner i_far (.clk_i(clk), .rst_n_i(rst_n), .en_i(part_en), .drv_i(pin_o),
        .oe_i(pin_oe), .pin_o(pin_i));

    // Clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Step edges; chain input is noise
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            trig_chain = ($urandom % 8 == 0);
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // Prescaled period
    function automatic int per_exp(input int l, input int p);
        return (l + 1) * (p + 1);
    endfunction

    // Strobe one write: 0 load, 1 prescale, 2 match, else control
    task automatic reg_wr(input int sel, input logic [1:0] wr, input logic [31:0] d);
        load_data = d;
        pre_data = d[15:0];
        match_data = d;
        ctl_data = d[15:0];
        if (sel == 0) load_wr = wr;
        else if (sel == 1) pre_wr = wr;
        else if (sel == 2) match_wr = wr;
        else ctl_wr = 1'b1;
        tick(1);
        {load_wr, pre_wr, match_wr, ctl_wr} = 7'h00;
    endtask

    // Bounded wait, cycles returned
    task automatic wait_to(input int b, input int lim, output int n);
        for (n = 0; n < lim && tmo[b] !== 1'b1; n++) tick(1);
        if (n == lim) begin
            $display("unexpected timeout_wait expected 1 seen 0");
            n_mismatch++;
            final_report();
        end
    endtask

    // Idle inputs, three reset cycles
    task automatic do_reset();
        {cfg, mode_a, mode_b, halt, alt_sel, part_en} = {3'h4, 13'h0000};
        {load_wr, pre_wr, match_wr, ctl_wr, trig_chain} = 8'h00;
        rst_n = 1'b0;
        tick(3);
        trig_chain = 1'b0;
        rst_n = 1'b1;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        n_mismatch = 0;
        tests_run = 0;
        i = $urandom(10765);
        do_reset();
        chk("count_rst", 32'hFFFFFFFF, count);
        chk("ctl_rst", 32'h0, ctl_o);
        $display("test reset done");
        // Split halves, trigger on A
        {mode_a, mode_b} = 8'h22;
        lv = 4 + $urandom % 12;
        pv = $urandom % 4;
        mv = 4 + $urandom % 12;
        reg_wr(0, 2'b11, {mv[15:0], lv[15:0]});
        chk("load_split", {mv[15:0], lv[15:0]}, count);
        reg_wr(1, 2'b01, pv);
        reg_wr(3, 2'b00, 32'h0105);
        wait_to(0, 2000, k);
        chk("trig_a", 1, adc_trig);
        tick(1);
        wait_to(0, 2000, k);
        chk("period_a", per_exp(lv, pv), k + 1);
        tick(1);
        wait_to(1, 2000, k);
        tick(1);
        wait_to(1, 2000, k);
        chk("period_b", per_exp(mv, 0), k + 1);
        // Debug halt with and without the stall bit
        halt = 1'b1;
        reg_wr(3, 2'b00, 32'h0107);
        snap = count[15:0];
        tick(6);
        chk("stall_hold", snap, count[15:0]);
        reg_wr(3, 2'b00, 32'h0105);
        snap = count[15:0];
        tick(pv + 1);
        chk("stall_off", 1, count[15:0] !== snap);
        halt = 1'b0;
        $display("test split done");
        // Joined timer
        do_reset();
        {cfg, mode_a} = 7'h01;
        reg_wr(0, 2'b10, $urandom);
        chk("load_b_refused", 32'hFFFFFFFF, count);
        reg_wr(0, 2'b01, 32'h00010001);
        chk("load_32", 32'h00010001, count);
        reg_wr(3, 2'b00, 32'h0001);
        for (i = 0; i < 8 && count[31:16] !== 16'h0000; i++) tick(1);
        chk("borrow", 32'h0000FFFF, count);
        reg_wr(0, 2'b01, 32'h6);
        wait_to(0, 40, k);
        tick(2);
        chk("oneshot_off", 0, ctl_o[0]);
        hi = 0;
        for (i = 0; i < 20; i++) begin
            tick(1);
            if (tmo[0] === 1'b1) hi++;
        end
        chk("oneshot_once", 0, hi);
        $display("test joined done");
        // RTC keeps counting under halt with stall set
        do_reset();
        {cfg, alt_sel, part_en, halt} = 8'h2B;
        reg_wr(2, 2'b01, 32'h3);
        reg_wr(3, 2'b00, 32'h0003);
        chk("rtc_first", 32'h1, count);
        wait_to(0, 400, k);
        chk("rtc_wrap", 0, count);
        $display("test rtc done");
        // Edge count then edge time on the odd pin
        do_reset();
        {mode_b, alt_sel} = 6'h0E;
        reg_wr(0, 2'b10, 32'h00140000);
        reg_wr(2, 2'b10, 32'h00050000);
        reg_wr(3, 2'b00, 32'h0100);
        part_en = 2'b10;
        hi = 0;
        for (i = 0; i < 60; i++) begin
            snap[0] = pin_i[1];
            tick(1);
            if (pin_i[1] === 1'b1 && snap[0] === 1'b0) hi++;
        end
        part_en = 2'b00;
        tick(4);
        chk("edge_count", 20 - hi, count[31:16]);
        mode_b = 4'h7;
        part_en = 2'b10;
        wait_to(1, 60, k);
        chk("edge_time", 1, capture[31:16] <= 16'h0014);
        $display("test capture done");
        // Pulse width with both polarities
        do_reset();
        {mode_a, alt_sel} = 6'h29;
        lv = 10 + $urandom % 10;
        mv = 1 + $urandom % 8;
        reg_wr(0, 2'b01, lv);
        reg_wr(2, 2'b01, mv);
        for (i = 0; i < 2; i++) begin
            reg_wr(3, 2'b00, i ? 32'h0009 : 32'h0001);
            tick(lv + 2);
            chk("pwm_oe", 1, pin_oe[0]);
            hi = 0;
            for (k = 0; k < 2 * (lv + 1); k++) begin
                if (pin_o[0] === 1'b1) hi++;
                tick(1);
            end
            chk("pwm_high", i ? 2 * mv : 2 * (lv - mv + 1), hi);
        end
        alt_sel = 2'b00;
        tick(1);
        chk("pin_gpio", 0, pin_oe);
        $display("test pwm done");
        final_report();
    end
endmodule
`default_nettype wire
